// ==== rtl/mds_supervisor.sv ====
// supervision of a two-motor power stage behind an axi4-lite register slave
// assumes synchronous inputs, one 200 MHz clock, faults sensed per physical output
`timescale 1ns/10ps
`include "mds_params.svh"

module mds_supervisor #(
  parameter int CYC_PER_MS = `MDS_CYC_PER_MS
) (
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  input  wire logic              ce_i,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [7:0]        s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  input  wire logic signed [7:0] demand_left_i,
  input  wire logic signed [7:0] demand_right_i,
  input  wire logic signed [7:0] correction_i,
  input  wire logic [9:0]        batt_dv_i,
  input  wire logic              current_limit_i,
  input  wire logic [1:0]        motor_open_i,
  input  wire logic [1:0]        pb_open_i,
  input  wire logic [1:0]        pb_short_i,
  output logic signed [10:0]     motor_dv_o [2],
  output logic [1:0]             bridge_en_o,
  output logic [1:0]             pb_energise_o,
  output logic                   pb_test_o,
  output logic [3:0]             flash_code_o
);

  // ------------------------------------------------------------
  // register file and axi4-lite slave
  // ------------------------------------------------------------
  mds_pkg::mds_ctrl_t  ctrl, next_ctrl;
  mds_pkg::mds_cfg_t   cfg, next_cfg;
  mds_pkg::mds_fault_t flt, next_flt;
  mds_pkg::mds_state_t st, next_st;
  logic                aw_ok, next_aw_ok, w_ok, next_w_ok;
  logic [7:0]          aw_adr, next_aw_adr;
  logic [31:0]         w_dat, next_w_dat;
  logic [3:0]          w_stb, next_w_stb;
  logic                bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0]          bresp, next_bresp, rresp, next_rresp;
  logic [31:0]         rdata, next_rdata;

  function automatic logic [15:0] lanes(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    lanes = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  assign s_axi_awready = !aw_ok && !bvalid;
  assign s_axi_wready  = !w_ok && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  always_comb begin
    logic [15:0] tmp;
    tmp         = 16'h0000;
    next_ctrl   = ctrl;
    next_cfg    = cfg;
    next_aw_ok  = aw_ok;
    next_aw_adr = aw_adr;
    next_w_ok   = w_ok;
    next_w_dat  = w_dat;
    next_w_stb  = w_stb;
    next_bvalid = bvalid;
    next_bresp  = bresp;
    next_rvalid = rvalid;
    next_rresp  = rresp;
    next_rdata  = rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_ok  = 1'b1;
      next_aw_adr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_ok  = 1'b1;
      next_w_dat = s_axi_wdata;
      next_w_stb = s_axi_wstrb;
    end
    if (aw_ok && w_ok) begin
      next_aw_ok  = 1'b0;
      next_w_ok   = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = `MDS_RESP_OKAY;
      // out-of-range values are pinned to the nearest legal setting
      if (aw_adr == `MDS_OFS_CTRL) begin
        tmp       = lanes({9'h000, ctrl}, w_dat, w_stb);
        next_ctrl = tmp[6:0];
      end else if (aw_adr == `MDS_OFS_STALL_TIME) begin
        tmp          = clamp(lanes({8'h00, cfg.stall_s}, w_dat, w_stb),
                             {8'h00, `MDS_STALL_MIN}, {8'h00, `MDS_STALL_MAX});
        next_cfg.stall_s = tmp[7:0];
      end else if (aw_adr == `MDS_OFS_MAX_VOLTS) begin
        tmp          = clamp(lanes({8'h00, cfg.max_v}, w_dat, w_stb),
                             {8'h00, `MDS_VOLT_MIN}, {8'h00, `MDS_VOLT_MAX});
        next_cfg.max_v = tmp[7:0];
      end else if (aw_adr == `MDS_OFS_SCALE) begin
        tmp          = clamp(lanes({8'h00, cfg.scale_pct}, w_dat, w_stb),
                             {8'h00, `MDS_SCALE_MIN}, {8'h00, `MDS_SCALE_MAX});
        next_cfg.scale_pct = tmp[7:0];
      end else if (aw_adr == `MDS_OFS_BRK_DELAY) begin
        next_cfg.brk_ms = clamp(lanes(cfg.brk_ms, w_dat, w_stb), `MDS_BRK_MIN, `MDS_BRK_MAX);
      end else if (aw_adr != `MDS_OFS_STATUS) begin
        next_bresp = `MDS_RESP_SLVERR;
      end
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = `MDS_RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      if (s_axi_araddr == `MDS_OFS_CTRL) begin
        next_rdata = {25'h0000000, ctrl};
      end else if (s_axi_araddr == `MDS_OFS_STALL_TIME) begin
        next_rdata = {24'h000000, cfg.stall_s};
      end else if (s_axi_araddr == `MDS_OFS_MAX_VOLTS) begin
        next_rdata = {24'h000000, cfg.max_v};
      end else if (s_axi_araddr == `MDS_OFS_SCALE) begin
        next_rdata = {24'h000000, cfg.scale_pct};
      end else if (s_axi_araddr == `MDS_OFS_BRK_DELAY) begin
        next_rdata = {16'h0000, cfg.brk_ms};
      end else if (s_axi_araddr == `MDS_OFS_STATUS) begin
        next_rdata = {23'h000000, st, flt.pb_short, flt.pb_open, flt.mot_open, flt.lock};
      end else begin
        next_rresp = `MDS_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl   <= `MDS_CTRL_RESET;
      cfg    <= {`MDS_STALL_DEF, `MDS_VOLT_DEF, `MDS_SCALE_DEF, `MDS_BRK_DEF};
      aw_ok  <= 1'b0;
      aw_adr <= 8'h00;
      w_ok   <= 1'b0;
      w_dat  <= 32'h0000_0000;
      w_stb  <= 4'h0;
      bvalid <= 1'b0;
      bresp  <= `MDS_RESP_OKAY;
      rvalid <= 1'b0;
      rresp  <= `MDS_RESP_OKAY;
      rdata  <= 32'h0000_0000;
    end else if (ce_i) begin
      ctrl   <= next_ctrl;
      cfg    <= next_cfg;
      aw_ok  <= next_aw_ok;
      aw_adr <= next_aw_adr;
      w_ok   <= next_w_ok;
      w_dat  <= next_w_dat;
      w_stb  <= next_w_stb;
      bvalid <= next_bvalid;
      bresp  <= next_bresp;
      rvalid <= next_rvalid;
      rresp  <= next_rresp;
      rdata  <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // supervision: stall timer, sequence, brake tests
  // ------------------------------------------------------------
  logic [17:0] pre, next_pre;
  logic [15:0] stall_ms, next_stall_ms;
  logic [15:0] seq_ms, next_seq_ms;
  logic        tick;
  logic        want;

  assign tick = (pre == 18'(CYC_PER_MS - 1));
  assign want = (demand_left_i != 8'sh00) || (demand_right_i != 8'sh00);

  always_comb begin
    next_pre      = tick ? 18'h00000 : pre + 18'h00001;
    next_stall_ms = stall_ms;
    next_flt      = flt;
    next_st       = st;
    next_seq_ms   = seq_ms;
    // stall timer only runs through an unbroken current-limit period
    if (!current_limit_i || st != mds_pkg::ST_DRIVE) begin
      next_stall_ms = 16'h0000;
    end else if (tick && ctrl.stall_en) begin
      next_stall_ms = stall_ms + 16'h0001;
    end
    if (ctrl.stall_en && stall_ms >= 16'(cfg.stall_s) * `MDS_MS_PER_S) begin
      next_flt.lock = 1'b1;
    end
    case (st)
      mds_pkg::ST_IDLE: begin
        if (want && !flt.lock) begin
          next_st = mds_pkg::ST_CHECK;
        end
      end
      mds_pkg::ST_CHECK: begin
        // a fresh check replaces the previous outcome, faults per physical output
        next_flt.mot_open = ctrl.cont_en ? motor_open_i : 2'b00;
        next_flt.pb_open  = pb_open_i & {ctrl.pb_dual, 1'b1};
        next_flt.pb_short = 2'b00;
        // an unused second brake in single mode must not block driving
        if ((ctrl.cont_en && motor_open_i != 2'b00) ||
            (pb_open_i & {ctrl.pb_dual, 1'b1}) != 2'b00) begin
          next_st = mds_pkg::ST_IDLE;
        end else begin
          next_st     = mds_pkg::ST_DRIVE;
          next_seq_ms = 16'h0000;
        end
      end
      mds_pkg::ST_DRIVE: begin
        if (tick) begin
          next_seq_ms = (seq_ms == `MDS_PB_TEST_MS) ? 16'h0000 : seq_ms + 16'h0001;
        end
        if (pb_test_o) begin
          next_flt.pb_open = flt.pb_open | (pb_open_i & {ctrl.pb_dual, 1'b1});
        end
        next_flt.pb_short = flt.pb_short | (pb_short_i & {ctrl.pb_dual, 1'b1});
        if (!want || next_flt.lock || next_flt.pb_open != 2'b00 ||
            next_flt.pb_short != 2'b00) begin
          next_st     = mds_pkg::ST_BRAKE;
          next_seq_ms = 16'h0000;
        end
      end
      mds_pkg::ST_BRAKE: begin
        if (tick) begin
          next_seq_ms = seq_ms + 16'h0001;
        end
        // one extra tick: the hold is never shorter than the delay
        if (seq_ms > cfg.brk_ms) begin
          next_st = mds_pkg::ST_IDLE;
        end
      end
      default: begin
        next_st = mds_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre      <= 18'h00000;
      stall_ms <= 16'h0000;
      flt      <= '0;
      st       <= mds_pkg::ST_IDLE;
      seq_ms   <= 16'h0000;
    end else if (ce_i) begin
      pre      <= next_pre;
      stall_ms <= next_stall_ms;
      flt      <= next_flt;
      st       <= next_st;
      seq_ms   <= next_seq_ms;
    end
  end

  // brake test pulse lasts one cycle per test period, only while driving
  assign pb_test_o     = ctrl.pb_test && st == mds_pkg::ST_DRIVE && tick &&
                         seq_ms == `MDS_PB_TEST_MS;
  assign pb_energise_o = (st == mds_pkg::ST_DRIVE) ? {ctrl.pb_dual, 1'b1} : 2'b00;
  assign bridge_en_o   = (st == mds_pkg::ST_DRIVE || st == mds_pkg::ST_BRAKE) ?
                         2'b11 : 2'b00;
  assign flash_code_o  = flt.lock ? `MDS_FLASH_STALL : 4'h0;

  // ------------------------------------------------------------
  // demand path: scale, correction, voltage ceiling, routing
  // ------------------------------------------------------------
  logic signed [7:0]  dem [2];
  logic signed [7:0]  cor [2];
  logic signed [10:0] vout [2], next_vout [2];
  logic [9:0]         vceil, vfull;
  logic [7:0]         dmax;

  assign vceil = 10'(cfg.max_v) * `MDS_DV_PER_V;
  assign vfull = (batt_dv_i < vceil) ? batt_dv_i : vceil;
  assign dmax  = 8'((16'(`MDS_DEMAND_FULL) * 16'(cfg.scale_pct)) / 16'(`MDS_PCT_FULL));

  for (genvar m = 0; m < 2; m++) begin : g_mot
    always_comb begin
      logic signed [15:0] p;
      p      = (m == 0) ? demand_left_i * $signed({8'h00, cfg.scale_pct})
                        : demand_right_i * $signed({8'h00, cfg.scale_pct});
      dem[m] = 8'(p / $signed(16'(`MDS_PCT_FULL)));
    end
  end

  // steering headroom: raise left for a positive correction and right for a negative one, slow the other only when both are at top
  always_comb begin
    logic signed [8:0] up;
    logic [1:0]        top;
    top    = {dem[1] >= $signed(dmax), dem[0] >= $signed(dmax)};
    cor[0] = dem[0];
    cor[1] = dem[1];
    up     = 9'sh000;
    if (correction_i > 8'sh00) begin
      up = dem[0] + correction_i;
      if (!top[0]) begin
        cor[0] = (up > $signed({1'b0, dmax})) ? dmax : up[7:0];
      end else if (top[1]) begin
        cor[1] = 8'(dem[1] - correction_i);
      end
    end else if (correction_i < 8'sh00) begin
      up = dem[1] - correction_i;
      if (!top[1]) begin
        cor[1] = (up > $signed({1'b0, dmax})) ? dmax : up[7:0];
      end else if (top[0]) begin
        cor[0] = 8'(dem[0] + correction_i);
      end
    end
  end

  for (genvar m = 0; m < 2; m++) begin : g_out
    always_comb begin
      logic signed [7:0]  d;
      logic signed [19:0] v;
      logic signed [19:0] lim;
      logic               inv;
      d   = (ctrl.swap ^ (m == 1)) ? cor[1] : cor[0];
      // invert belongs to the logical motor, so it follows the swap
      inv = ((m == 1) ^ ctrl.swap) ? ctrl.inv_r : ctrl.inv_l;
      lim = $signed({10'h000, vfull});
      v   = (d * lim) / $signed(20'(`MDS_DEMAND_FULL));
      // a full reverse demand of -128 would overshoot the ceiling
      if (v > lim) begin
        v = lim;
      end else if (v < -lim) begin
        v = -lim;
      end
      if (inv) begin
        v = -v;
      end
      // drive drops in the same cycle as the lockout is set
      next_vout[m] = (st == mds_pkg::ST_DRIVE && !next_flt.lock) ? 11'(v) : 11'sh000;
    end
    always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        vout[m] <= 11'sh000;
      end else if (ce_i) begin
        vout[m] <= next_vout[m];
      end
    end
    assign motor_dv_o[m] = vout[m];
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_brake_entry;
    ce_i && st == mds_pkg::ST_DRIVE && next_st == mds_pkg::ST_BRAKE;
  endsequence
  sequence s_braking;
    bridge_en_o == 2'b11 && pb_energise_o == 2'b00;
  endsequence

  a_lock_flash: assert property (flt.lock |-> flash_code_o == `MDS_FLASH_STALL &&
    motor_dv_o[0] == 11'sh000 && motor_dv_o[1] == 11'sh000)
    else $error("lockout without flash or with drive");
  a_lock_sticky: assert property (flt.lock |=> flt.lock)
    else $error("stall lockout cleared without reset");
  a_stall_trip: assert property (ce_i && ctrl.stall_en && st == mds_pkg::ST_DRIVE &&
    stall_ms >= 16'(cfg.stall_s) * `MDS_MS_PER_S |=> flt.lock)
    else $error("stall not caught");
  a_stall_restart: assert property (ce_i && !current_limit_i |=> stall_ms == 16'h0000)
    else $error("stall timer kept running");
  a_cont_fault: assert property (ce_i && st == mds_pkg::ST_CHECK && ctrl.cont_en &&
    motor_open_i != 2'b00 |=> flt.mot_open != 2'b00 && st == mds_pkg::ST_IDLE)
    else $error("open motor not flagged");
  // outputs are registered, so they answer to the ceiling of the cycle before
  a_volt_ceiling: assert property (motor_dv_o[0] <= $signed({1'b0, $past(vceil)}) &&
    motor_dv_o[0] >= -$signed({1'b0, $past(vceil)}) &&
    motor_dv_o[1] <= $signed({1'b0, $past(vceil)}) &&
    motor_dv_o[1] >= -$signed({1'b0, $past(vceil)}))
    else $error("motor voltage above ceiling");
  a_pb_single: assert property (!ctrl.pb_dual |-> !pb_energise_o[1])
    else $error("second brake driven in single mode");
  a_brake_hold: assert property (s_brake_entry |=> s_braking [*2])
    else $error("active braking too short");
  a_pb_test_off: assert property (!ctrl.pb_test |-> !pb_test_o)
    else $error("brake test during drive while disabled");
  a_short_test: assert property (ce_i && st == mds_pkg::ST_DRIVE && pb_short_i[0] |=>
    flt.pb_short[0] && st == mds_pkg::ST_BRAKE)
    else $error("brake short missed");

endmodule

// ==== common/mds_params.svh ====
// constants of the motor drive supervisor: offsets, field positions, resets, timing
// assumes a 200 MHz clock and an axi4-lite register bus with 32-bit data
`ifndef MDS_PARAMS_SVH
`define MDS_PARAMS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define MDS_OFS_CTRL       8'h00
`define MDS_OFS_STALL_TIME 8'h04
`define MDS_OFS_MAX_VOLTS  8'h08
`define MDS_OFS_SCALE      8'h0c
`define MDS_OFS_BRK_DELAY  8'h10
`define MDS_OFS_STATUS     8'h14

// ------------------------------------------------------------
// control bits and status bits
// ------------------------------------------------------------
`define MDS_CTRL_STALL_EN  0
`define MDS_CTRL_CONT_EN   1
`define MDS_CTRL_PB_DUAL   2
`define MDS_CTRL_PB_TEST   3
`define MDS_CTRL_SWAP      4
`define MDS_CTRL_INV_L     5
`define MDS_CTRL_INV_R     6
`define MDS_CTRL_RESET     7'h0f
`define MDS_ST_LOCK        0
`define MDS_ST_MOT_LSB     1
`define MDS_ST_PBO_LSB     3
`define MDS_ST_PBS_LSB     5
`define MDS_ST_STATE_LSB   7

// ------------------------------------------------------------
// programmable ranges and defaults
// ------------------------------------------------------------
`define MDS_STALL_MIN      8'h05
`define MDS_STALL_MAX      8'h32
`define MDS_STALL_DEF      8'h0f
`define MDS_VOLT_MIN       8'h18
`define MDS_VOLT_MAX       8'h1e
`define MDS_VOLT_DEF       8'h1a
`define MDS_SCALE_MIN      8'h32
`define MDS_SCALE_MAX      8'h64
`define MDS_SCALE_DEF      8'h5f
`define MDS_BRK_MIN        16'h0064
`define MDS_BRK_MAX        16'h03e8
`define MDS_BRK_DEF        16'h01f4

// ------------------------------------------------------------
// timing and scaling
// ------------------------------------------------------------
`define MDS_CLK_PERIOD_PS  5000
`define MDS_MS_PS          1000000000
`define MDS_CYC_PER_MS     (`MDS_MS_PS / `MDS_CLK_PERIOD_PS)
`define MDS_MS_PER_S       16'h03e8
`define MDS_PB_TEST_MS     16'h00c8
`define MDS_DV_PER_V       10'h00a
`define MDS_DEMAND_FULL    8'h7f
`define MDS_PCT_FULL       8'h64
`define MDS_FLASH_STALL    4'hb
`define MDS_RESP_OKAY      2'h0
`define MDS_RESP_SLVERR    2'h2

`endif

// ==== common/mds_pkg.sv ====
// types of the motor drive supervisor
// assumes mds_params.svh for all figures
package mds_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CHECK,
    ST_DRIVE,
    ST_BRAKE
  } mds_state_t;

  typedef struct packed {
    logic       inv_r;
    logic       inv_l;
    logic       swap;
    logic       pb_test;
    logic       pb_dual;
    logic       cont_en;
    logic       stall_en;
  } mds_ctrl_t;

  typedef struct packed {
    logic [7:0]  stall_s;
    logic [7:0]  max_v;
    logic [7:0]  scale_pct;
    logic [15:0] brk_ms;
  } mds_cfg_t;

  typedef struct packed {
    logic       lock;
    logic [1:0] mot_open;
    logic [1:0] pb_open;
    logic [1:0] pb_short;
  } mds_fault_t;

endpackage

// ==== test/mds_plant.sv ====
// far side of the supervisor: two motors and two park brakes
// assumes the bench commands every fault through the cut, bad and jam inputs
`timescale 1ns/10ps

module mds_plant (
  input  wire logic       clock_i,
  input  wire logic [1:0] bridge_en_i,
  input  wire logic [1:0] pb_energise_i,
  input  wire logic       jam_i,
  input  wire logic [1:0] mot_cut_i,
  input  wire logic [1:0] pb_cut_i,
  input  wire logic [1:0] pb_bad_i,
  output logic            current_limit_o,
  output logic [1:0]      motor_open_o,
  output logic [1:0]      pb_open_o,
  output logic [1:0]      pb_short_o
);
  // a jammed wheel only draws limit current while a bridge drives it
  // a shorted brake only shows while it is energised
  always_ff @(posedge clock_i) begin
    current_limit_o <= jam_i && (bridge_en_i != 2'h0);
    motor_open_o    <= mot_cut_i;
    pb_open_o       <= pb_cut_i;
    pb_short_o      <= pb_bad_i & pb_energise_i;
  end
endmodule

// ==== test/tb_motor_drive_supervisor.sv ====
// self-checking bench of the motor drive supervisor with its plant model
// assumes a shortened millisecond of 10 cycles to keep the run small
`timescale 1ns/10ps
`include "mds_params.svh"

module tb_motor_drive_supervisor;
  localparam int CPM = 10;
  logic clock_i = 1'b0, rst_b_i = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  logic arv = 1'b0, rry = 1'b0, jam = 1'b0, ce = 1'b1, cl, awr, wr, bv, arr, rv, pbt;
  logic [7:0] awa = 8'h0, ara = 8'h0;
  logic [31:0] wd = 32'h0, rd, rdat;
  logic [1:0] bresp, rresp, rr, mo, po, ps, br, pbe, mcut = 2'h0, pbad = 2'h0, pcut = 2'h0;
  logic signed [7:0] dl = 8'sh0, dr = 8'sh0, corr = 8'sh0;
  logic [9:0] batt = 10'h12c;
  logic signed [10:0] mdv [2];
  logic [3:0] fl;
  logic [15:0] lfsr = 16'h8c1d;
  int miscompares = 0, total_checks = 0, cyc = 0, n, sc;
  logic [7:0] ctl [5] = '{8'h0f, 8'h0b, 8'h3f, 8'h4b, 8'h07};
  always #2.5 clock_i = ~clock_i;
  mds_supervisor #(.CYC_PER_MS(CPM)) DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .demand_left_i(dl), .demand_right_i(dr), .correction_i(corr),
    .batt_dv_i(batt), .current_limit_i(cl), .motor_open_i(mo), .pb_open_i(po),
    .pb_short_i(ps), .motor_dv_o(mdv), .bridge_en_o(br), .pb_energise_o(pbe),
    .pb_test_o(pbt), .flash_code_o(fl));
  mds_plant PLANT (.clock_i(clock_i), .bridge_en_i(br), .pb_energise_i(pbe), .jam_i(jam),
    .mot_cut_i(mcut), .pb_cut_i(pcut), .pb_bad_i(pbad), .current_limit_o(cl),
    .motor_open_o(mo), .pb_open_o(po), .pb_short_o(ps));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // applied voltage for a demand, full scale never above the ceiling
  function automatic logic [31:0] volts(input int d, input int s, input int b, input bit inv);
    int full;
    int v;
    full = (b < 240) ? b : 240;
    v = ((d * s) / 100 * full) / 127;
    return 32'(inv ? -v : v);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bry <= 1'b1;
    do begin
      @(posedge clock_i);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    bry <= 1'b0;
    chk("bresp", 32'h0, 32'(bresp));
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clock_i);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do begin
      @(posedge clock_i);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rry <= 1'b0;
    rdat = rd;
    rr = rresp;
    chk("rresp", 32'(er), 32'(rr));
    if (er == 2'h0) chk("rdata", e, rdat);
  endtask
  // bounded wait for the brake outputs to reach a value
  task automatic wpb(input logic [1:0] e, input int lim);
    n = 0;
    while (pbe !== e && n < lim) begin
      @(posedge clock_i);
      n++;
    end
  endtask

  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rchk(`MDS_OFS_CTRL, 32'h0f, 2'h0);
    rchk(`MDS_OFS_STALL_TIME, 32'h0f, 2'h0);
    rchk(`MDS_OFS_MAX_VOLTS, 32'h1a, 2'h0);
    rchk(`MDS_OFS_SCALE, 32'h5f, 2'h0);
    rchk(`MDS_OFS_BRK_DELAY, 32'h1f4, 2'h0);
    rchk(8'h18, 32'h0, 2'h2);
    wreg(`MDS_OFS_MAX_VOLTS, 32'h18);
    wreg(`MDS_OFS_BRK_DELAY, 32'h10);
    rchk(`MDS_OFS_BRK_DELAY, 32'h64, 2'h0);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      lfsr = nxt(lfsr);
      sc = 50 + int'(lfsr[7:0]) % 51;
      wreg(`MDS_OFS_SCALE, 32'(sc));
      wreg(`MDS_OFS_CTRL, 32'(ctl[i]));
      @(posedge clock_i);
      dl <= 8'sh7f;
      dr <= {lfsr[15], 7'(lfsr[14:8] | 7'h1)};
      batt <= 10'(200 + int'(lfsr[5:0]));
      wpb(ctl[i][2] ? 2'h3 : 2'h1, 20);
      chk("brake out", 32'(ctl[i][2] ? 2'h3 : 2'h1), 32'(pbe));
      repeat (3) @(posedge clock_i);
      chk("out0", volts(ctl[i][4] ? dr : dl, sc, batt, ctl[i][4] ? ctl[i][6] : ctl[i][5]),
          32'(mdv[0]));
      chk("out1", volts(ctl[i][4] ? dl : dr, sc, batt, ctl[i][4] ? ctl[i][5] : ctl[i][6]),
          32'(mdv[1]));
      n = 0;
      repeat (2100) @(posedge clock_i) n += pbt;
      chk("brake test seen", 32'(ctl[i][3]), 32'(n > 0));
      dl <= 8'sh0;
      dr <= 8'sh0;
      wpb(2'h0, 20);
      repeat (2) @(posedge clock_i);
      chk("brake volts", 32'h0, 32'(mdv[0]));
      n = 0;
      while (br !== 2'h0 && n < 1200) begin
        @(posedge clock_i);
        n++;
      end
      chk("bridge hold", 32'h1, 32'(n >= 998 && n <= 1012));
    end
    // steering at full scale: raise left, then slow right once both are at top
    wreg(`MDS_OFS_SCALE, 32'h64);
    corr <= 8'sh10;
    dl <= 8'sh40;
    dr <= 8'sh40;
    wpb(2'h3, 20);
    repeat (3) @(posedge clock_i);
    chk("steer up", volts(80, 100, batt, 1'b0), 32'(mdv[0]));
    ce <= 1'b0;
    dl <= 8'sh7f;
    dr <= 8'sh7f;
    repeat (3) @(posedge clock_i);
    chk("steer hold", volts(64, 100, batt, 1'b0), 32'(mdv[1]));
    ce <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk("steer down", volts(111, 100, batt, 1'b0), 32'(mdv[1]));
    corr <= 8'sh0;
    dl <= 8'sh0;
    dr <= 8'sh0;
    repeat (1100) @(posedge clock_i);
    $display("test drive done");
    wreg(`MDS_OFS_CTRL, 32'h1f);
    mcut <= 2'h2;
    pcut <= 2'h2;
    dl <= 8'sh40;
    repeat (20) @(posedge clock_i);
    chk("bridge open", 32'h0, 32'(br));
    dl <= 8'sh0;
    rchk(`MDS_OFS_STATUS, 32'h14, 2'h0);
    mcut <= 2'h0;
    pcut <= 2'h0;
    wreg(`MDS_OFS_CTRL, 32'h07);
    dl <= 8'sh40;
    wpb(2'h3, 20);
    pbad <= 2'h1;
    wpb(2'h0, 20);
    chk("short stop", 32'h1, 32'(n < 20));
    dl <= 8'sh0;
    pbad <= 2'h0;
    repeat (1100) @(posedge clock_i);
    $display("test faults done");
    wreg(`MDS_OFS_STALL_TIME, 32'h1);
    rchk(`MDS_OFS_STALL_TIME, 32'h5, 2'h0);
    jam <= 1'b1;
    dl <= 8'sh7f;
    wpb(2'h3, 20);
    wpb(2'h0, 51000);
    chk("stall time", 32'h1, 32'(n >= 49990 && n <= 50020));
    repeat (2) @(posedge clock_i);
    chk("flash", 32'hb, 32'(fl));
    jam <= 1'b0;
    repeat (1200) @(posedge clock_i);
    chk("locked", 32'h0, 32'(br));
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    wpb(2'h3, 20);
    chk("unlocked", 32'h0, 32'(fl));
    $display("test stall done");
    print_verdict();
  end
endmodule
